// [design/direct_io_function_mux.sv]
// routing between the terminals of the io connector and internal functions
//
// Behaviour
// - each input terminal drives the function its code picks; 0 unused
// - reset codes: limit plus, limit minus, home sensor, stop
// - one function picked by several terminals is the OR of them
// - panel lock release stays on when no terminal picks it
// - panel lock release on terminal and network is the AND of both
// - polarity 0 normally open, 1 normally closed inverts the level
// - each output terminal drives the signal its code picks; 0 unused
// - reset codes: output zero fault status, output one ready
// - codes 1-13, 16-18, 48-53 and 60-63 echo the input function of that code
// - codes 32-47 show general bits zero to fifteen
// - code 65 is active while no fault exists
// - codes 66, 67, 68, 70 show caution, ready, moving, home position
// - code 72 shows the tick given every 7.2 degrees of rotation
// - codes 73-75 show position inside zones one to three
// - code 80 shows the internal busy state
// - functions 48-53 form the six-bit operation data number
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module direct_io_function_mux (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // io connector terminals
  input wire logic [dio_pkg::IN_TERMS-1:0] IN_TERM_I,
  output logic [dio_pkg::OUT_TERMS-1:0] OUT_TERM_O,
  // network side and general bits
  input wire logic [dio_pkg::FUNC_W-1:0] NET_FUNC_I,
  input wire logic NET_PANEL_LOCK_ASSIGNED_I,
  input wire logic [dio_pkg::GP_W-1:0] GENERAL_BITS_I,
  // motion status
  input wire logic FAULT_I,
  input wire logic CAUTION_I,
  input wire logic READY_I,
  input wire logic MOVING_I,
  input wire logic HOME_POS_I,
  input wire logic ROTATION_TICK_I,
  input wire logic [2:0] ZONE_I,
  input wire logic INTERNAL_BUSY_I,
  // decoded functions
  output logic [dio_pkg::FUNC_W-1:0] FUNC_O,
  output logic [dio_pkg::OP_DATA_W-1:0] OP_DATA_NO_O,
  // register port
  input wire logic [dio_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [dio_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [dio_pkg::DATA_W-1:0] REG_RDATA_O
);
  import dio_pkg::*;

  typedef struct packed {
    logic [IN_TERMS-1:0][7:0] in_sel;
    logic [IN_TERMS-1:0] in_pol;
    logic [OUT_TERMS-1:0][7:0] out_sel;
    logic [FUNC_W-1:0] func;
    logic [GP_W-1:0] gp;
    logic [STATUS_W-1:0] status;
    logic [OUT_TERMS-1:0] out;
    logic [DATA_W-1:0] rdata;
  } mux_state_t;

  mux_state_t st_reg, st_next;

  logic [IN_TERMS-1:0] level;
  logic [IN_TERMS-1:0] term_active;
  logic [IN_TERMS-1:0] panel_sel;
  logic [IN_TERMS-1:0][FUNC_W-1:0] term_hit;
  logic [FUNC_W-1:0] direct_func;
  logic [OUT_TERMS-1:0] out_level;
  logic direct_panel;
  logic panel_level;
  logic [OP_DATA_W-1:0] op_src;
  logic [5:0] sel0_idx;
  logic gp_pick0;
  logic echo_pick1;

  ////////////////////////////////////////////////////////////////////////////
  // terminal inputs come from outside, so they pass the synchroniser

  input_sync #(
    .WIDTH(IN_TERMS)
  ) u_sync (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .pin_i(IN_TERM_I),
    .level_o(level)
  );

  assign term_active = level ^ st_reg.in_pol;

  ////////////////////////////////////////////////////////////////////////////
  // per-terminal decode and per-output selection

  for (genvar t = 0; t < IN_TERMS; t++) begin : g_in
    // codes above 63 or not in the list never set a function bit
    assign term_hit[t] = (in_code_valid(st_reg.in_sel[t]) && term_active[t])
                       ? (FUNC_W'(1) << st_reg.in_sel[t][5:0])
                       : '0;
    assign panel_sel[t] = st_reg.in_sel[t] == CODE_PANEL_LOCK;
  end

  for (genvar o = 0; o < OUT_TERMS; o++) begin : g_out
    output_select u_sel (
      .code_i(st_reg.out_sel[o]),
      .func_i(st_reg.func),
      .gp_i(st_reg.gp),
      .status_i(st_reg.status),
      .level_o(out_level[o])
    );
  end

  always_comb begin
    direct_func = '0;
    for (int t = 0; t < IN_TERMS; t++) begin
      direct_func = direct_func | term_hit[t];
    end
  end

  // panel lock release: free when no terminal takes it, else AND with net when the network also takes it
  assign direct_panel = |(term_active & panel_sel);
  assign panel_level = (|panel_sel)
                     ? (direct_panel & (NET_PANEL_LOCK_ASSIGNED_I ?
                        NET_FUNC_I[CODE_PANEL_LOCK[5:0]] : 1'b1))
                     : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    // network bits for unlisted codes are dropped as well
    st_next.func = (direct_func | NET_FUNC_I) & IN_CODE_MASK;
    st_next.func[CODE_PANEL_LOCK[5:0]] = panel_level;
    st_next.gp = GENERAL_BITS_I;
    st_next.status[ST_FAULT] = FAULT_I;
    st_next.status[ST_CAUTION] = CAUTION_I;
    st_next.status[ST_READY] = READY_I;
    st_next.status[ST_MOVING] = MOVING_I;
    st_next.status[ST_HOME_POS] = HOME_POS_I;
    st_next.status[ST_TICK] = ROTATION_TICK_I;
    st_next.status[ST_ZONE_ONE] = ZONE_I[0];
    st_next.status[ST_ZONE_TWO] = ZONE_I[1];
    st_next.status[ST_ZONE_THREE] = ZONE_I[2];
    st_next.status[ST_BUSY] = INTERNAL_BUSY_I;
    st_next.out = out_level;
    st_next.rdata = '0;
    // codes are stored whole so that an out-of-range code reads back as set
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        ADDR_IN_SEL0: st_next.in_sel[0] = REG_WDATA_I;
        ADDR_IN_SEL1: st_next.in_sel[1] = REG_WDATA_I;
        ADDR_IN_SEL2: st_next.in_sel[2] = REG_WDATA_I;
        ADDR_IN_SEL3: st_next.in_sel[3] = REG_WDATA_I;
        ADDR_IN_POL: st_next.in_pol = REG_WDATA_I[IN_TERMS-1:0];
        ADDR_OUT_SEL0: st_next.out_sel[0] = REG_WDATA_I;
        ADDR_OUT_SEL1: st_next.out_sel[1] = REG_WDATA_I;
        default: st_next.rdata = '0;
      endcase
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_IN_SEL0: st_next.rdata = st_reg.in_sel[0];
        ADDR_IN_SEL1: st_next.rdata = st_reg.in_sel[1];
        ADDR_IN_SEL2: st_next.rdata = st_reg.in_sel[2];
        ADDR_IN_SEL3: st_next.rdata = st_reg.in_sel[3];
        ADDR_IN_POL: st_next.rdata = {4'h0, st_reg.in_pol};
        ADDR_OUT_SEL0: st_next.rdata = st_reg.out_sel[0];
        ADDR_OUT_SEL1: st_next.rdata = st_reg.out_sel[1];
        ADDR_TERM_STATUS: st_next.rdata = {2'h0, st_reg.out, level};
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_reg <= '0;
      st_reg.in_sel[0] <= RST_IN_SEL0;
      st_reg.in_sel[1] <= RST_IN_SEL1;
      st_reg.in_sel[2] <= RST_IN_SEL2;
      st_reg.in_sel[3] <= RST_IN_SEL3;
      st_reg.in_pol <= RST_IN_POL;
      st_reg.out_sel[0] <= RST_OUT_SEL0;
      st_reg.out_sel[1] <= RST_OUT_SEL1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign OUT_TERM_O = st_reg.out;
  assign FUNC_O = st_reg.func;
  // the data number is simply bits 48 to 53 of the function vector
  assign OP_DATA_NO_O = st_reg.func[CODE_OP_DATA_SELECT_BIT5[5:0]:
                                    CODE_OP_DATA_SELECT_BIT0[5:0]];
  assign REG_RDATA_O = st_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  assign op_src = direct_func[CODE_OP_DATA_SELECT_BIT5[5:0]:
                              CODE_OP_DATA_SELECT_BIT0[5:0]] |
                  NET_FUNC_I[CODE_OP_DATA_SELECT_BIT5[5:0]:
                             CODE_OP_DATA_SELECT_BIT0[5:0]];
  assign sel0_idx = st_reg.in_sel[0][5:0];
  assign gp_pick0 = st_reg.gp[st_reg.out_sel[0][3:0]];
  assign echo_pick1 = st_reg.func[st_reg.out_sel[1][5:0]];

  AST_IN_RESET: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    $fell(RST_I) |-> (st_reg.in_sel[0] == RST_IN_SEL0 &&
      st_reg.in_sel[1] == RST_IN_SEL1 && st_reg.in_sel[2] == RST_IN_SEL2 &&
      st_reg.in_sel[3] == RST_IN_SEL3 && st_reg.in_pol == RST_IN_POL))
    else $error("input selections not at reset values");

  AST_OUT_RESET: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    $fell(RST_I) |-> (st_reg.out_sel[0] == RST_OUT_SEL0 &&
      st_reg.out_sel[1] == RST_OUT_SEL1))
    else $error("output selections not at reset values");

  AST_IN_ROUTE: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (term_active[0] && in_code_valid(st_reg.in_sel[0]) &&
     st_reg.in_sel[0] != CODE_PANEL_LOCK) |=> st_reg.func[$past(sel0_idx)])
    else $error("active terminal zero did not raise its function");

  AST_CODE_ZERO: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    ##1 !st_reg.func[0])
    else $error("code zero raised a function");

  AST_NORMALLY_CLOSED: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.in_pol[0] && !level[0] && in_code_valid(st_reg.in_sel[0]) &&
     st_reg.in_sel[0] != CODE_PANEL_LOCK) |=> st_reg.func[$past(sel0_idx)])
    else $error("open normally closed terminal not seen as active");

  AST_PANEL_FREE: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (panel_sel == '0) |=> st_reg.func[CODE_PANEL_LOCK[5:0]])
    else $error("panel lock release not held on");

  AST_PANEL_AND: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    ((|panel_sel) && NET_PANEL_LOCK_ASSIGNED_I &&
     !NET_FUNC_I[CODE_PANEL_LOCK[5:0]])
    |=> !st_reg.func[CODE_PANEL_LOCK[5:0]])
    else $error("panel lock release on without network side");

  AST_FAULT_NC: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[0] == CODE_FAULT)
    |=> (OUT_TERM_O[0] == !$past(FAULT_I, 2)))
    else $error("fault output not normally closed");

  AST_READY_OUT: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[1] == CODE_READY) |=> (OUT_TERM_O[1] == $past(READY_I, 2)))
    else $error("ready output does not follow ready status");

  AST_GENERAL_BIT: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[0] >= CODE_GENERAL_BIT_ZERO &&
     st_reg.out_sel[0] <= CODE_GENERAL_BIT_FIFTEEN)
    |=> (OUT_TERM_O[0] == $past(gp_pick0)))
    else $error("output does not show the general bit");

  AST_BAD_OUT_CODE: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[0] > CODE_INTERNAL_BUSY ||
     st_reg.out_sel[0] == CODE_NONE) |=> !OUT_TERM_O[0])
    else $error("unused output code drove the terminal");

  AST_OP_DATA: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    ##1 (OP_DATA_NO_O == $past(op_src)))
    else $error("operation data number does not follow its bits");

  AST_NORMALLY_OPEN: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (!st_reg.in_pol[0] && level[0] && in_code_valid(st_reg.in_sel[0]) &&
     st_reg.in_sel[0] != CODE_PANEL_LOCK) |=> st_reg.func[$past(sel0_idx)])
    else $error("conducting normally open terminal not seen as active");

  AST_CAUTION_OUT: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[0] == CODE_CAUTION)
    |=> (OUT_TERM_O[0] == $past(CAUTION_I, 2)))
    else $error("caution output does not follow caution status");

  AST_MOVING_OUT: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[0] == CODE_MOVING)
    |=> (OUT_TERM_O[0] == $past(MOVING_I, 2)))
    else $error("moving output does not follow moving status");

  AST_HOME_OUT: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[0] == CODE_HOME_POS)
    |=> (OUT_TERM_O[0] == $past(HOME_POS_I, 2)))
    else $error("home output does not follow home status");

  AST_TICK_OUT: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[0] == CODE_ROTATION_TICK)
    |=> (OUT_TERM_O[0] == $past(ROTATION_TICK_I, 2)))
    else $error("tick output does not follow the rotation tick");

  AST_ZONE_OUT: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[0] == CODE_ZONE_THREE)
    |=> (OUT_TERM_O[0] == $past(ZONE_I[2], 2)))
    else $error("zone output does not follow zone three");

  AST_BUSY_OUT: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    (st_reg.out_sel[0] == CODE_INTERNAL_BUSY)
    |=> (OUT_TERM_O[0] == $past(INTERNAL_BUSY_I, 2)))
    else $error("busy output does not follow internal busy");

  AST_ECHO_OUT: assert property (@(posedge CORE_CLK_I)
    disable iff (RST_I)
    ((st_reg.out_sel[1] >= CODE_OP_DATA_SELECT_BIT0 &&
      st_reg.out_sel[1] <= CODE_OP_DATA_SELECT_BIT5) ||
     (st_reg.out_sel[1] >= CODE_POSITIVE_LIMIT &&
      st_reg.out_sel[1] <= CODE_SLOT_SENSOR))
    |=> (OUT_TERM_O[1] == $past(echo_pick1)))
    else $error("echo output does not follow its input function");

endmodule
`default_nettype wire

// [include/dio_pkg.sv]
// constants, codes and helper functions of the direct terminal function mux
`default_nettype none
package dio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int IN_TERMS = 4;
  localparam int OUT_TERMS = 2;
  localparam int SYNC_STAGES = 3;
  localparam int FUNC_W = 64;
  localparam int GP_W = 16;
  localparam int STATUS_W = 10;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int OP_DATA_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ADDR_IN_SEL0 = 8'h00;
  localparam logic [7:0] ADDR_IN_SEL1 = 8'h01;
  localparam logic [7:0] ADDR_IN_SEL2 = 8'h02;
  localparam logic [7:0] ADDR_IN_SEL3 = 8'h03;
  localparam logic [7:0] ADDR_IN_POL = 8'h04;
  localparam logic [7:0] ADDR_OUT_SEL0 = 8'h05;
  localparam logic [7:0] ADDR_OUT_SEL1 = 8'h06;
  localparam logic [7:0] ADDR_TERM_STATUS = 8'h07;

  ////////////////////////////////////////////////////////////////////////////
  // function codes (decimal value in the comment)
  localparam logic [7:0] CODE_NONE = 8'h00;             // 0
  localparam logic [7:0] CODE_RUN_POSITIVE = 8'h01;     // 1
  localparam logic [7:0] CODE_DIRECT_LAST = 8'h0d;      // 13
  localparam logic [7:0] CODE_BRAKE_RELEASE = 8'h10;    // 16
  localparam logic [7:0] CODE_STOP = 8'h12;             // 18
  localparam logic [7:0] CODE_FAULT_CLEAR = 8'h18;      // 24
  localparam logic [7:0] CODE_POSITION_PRESET = 8'h19;  // 25
  localparam logic [7:0] CODE_PANEL_LOCK = 8'h1b;       // 27
  localparam logic [7:0] CODE_GENERAL_BIT_ZERO = 8'h20;    // 32
  localparam logic [7:0] CODE_GENERAL_BIT_FIFTEEN = 8'h2f; // 47
  localparam logic [7:0] CODE_OP_DATA_SELECT_BIT0 = 8'h30; // 48
  localparam logic [7:0] CODE_OP_DATA_SELECT_BIT5 = 8'h35; // 53
  localparam logic [7:0] CODE_POSITIVE_LIMIT = 8'h3c;   // 60
  localparam logic [7:0] CODE_NEGATIVE_LIMIT = 8'h3d;   // 61
  localparam logic [7:0] CODE_HOME_SENSOR = 8'h3e;      // 62
  localparam logic [7:0] CODE_SLOT_SENSOR = 8'h3f;      // 63
  localparam logic [7:0] CODE_FAULT = 8'h41;            // 65
  localparam logic [7:0] CODE_CAUTION = 8'h42;          // 66
  localparam logic [7:0] CODE_READY = 8'h43;            // 67
  localparam logic [7:0] CODE_MOVING = 8'h44;           // 68
  localparam logic [7:0] CODE_HOME_POS = 8'h46;         // 70
  localparam logic [7:0] CODE_ROTATION_TICK = 8'h48;    // 72
  localparam logic [7:0] CODE_ZONE_ONE = 8'h49;         // 73
  localparam logic [7:0] CODE_ZONE_TWO = 8'h4a;         // 74
  localparam logic [7:0] CODE_ZONE_THREE = 8'h4b;       // 75
  localparam logic [7:0] CODE_INTERNAL_BUSY = 8'h50;    // 80

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] RST_IN_SEL0 = CODE_POSITIVE_LIMIT;
  localparam logic [7:0] RST_IN_SEL1 = CODE_NEGATIVE_LIMIT;
  localparam logic [7:0] RST_IN_SEL2 = CODE_HOME_SENSOR;
  localparam logic [7:0] RST_IN_SEL3 = CODE_STOP;
  localparam logic [3:0] RST_IN_POL = 4'h0;
  localparam logic [7:0] RST_OUT_SEL0 = CODE_FAULT;
  localparam logic [7:0] RST_OUT_SEL1 = CODE_READY;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions of the motion status vector
  localparam int ST_FAULT = 0;
  localparam int ST_CAUTION = 1;
  localparam int ST_READY = 2;
  localparam int ST_MOVING = 3;
  localparam int ST_HOME_POS = 4;
  localparam int ST_TICK = 5;
  localparam int ST_ZONE_ONE = 6;
  localparam int ST_ZONE_TWO = 7;
  localparam int ST_ZONE_THREE = 8;
  localparam int ST_BUSY = 9;

  ////////////////////////////////////////////////////////////////////////////
  // codes that name an input function
  function automatic logic in_code_valid(input logic [7:0] c);
    return (c >= CODE_RUN_POSITIVE && c <= CODE_DIRECT_LAST) ||
           (c >= CODE_BRAKE_RELEASE && c <= CODE_STOP) ||
           c == CODE_FAULT_CLEAR || c == CODE_POSITION_PRESET ||
           c == CODE_PANEL_LOCK ||
           (c >= CODE_GENERAL_BIT_ZERO && c <= CODE_OP_DATA_SELECT_BIT5) ||
           (c >= CODE_POSITIVE_LIMIT && c <= CODE_SLOT_SENSOR);
  endfunction

  function automatic logic [FUNC_W-1:0] in_code_mask();
    logic [FUNC_W-1:0] m;
    m = '0;
    for (int i = 0; i < FUNC_W; i++) begin
      m[i] = in_code_valid(8'(i));
    end
    return m;
  endfunction

  localparam logic [FUNC_W-1:0] IN_CODE_MASK = in_code_mask();

endpackage
`default_nettype wire

// [design/input_sync.sv]
// three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw pins and settled levels
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t st_reg, st_next;

  if (WIDTH < 1) begin : g_check
    $error("input_sync needs at least one bit");
  end

  // s1 feeds s2 only; the agreement test looks at s2 and s3
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.level = (st_reg.s2 & st_reg.s3) |
                    (st_reg.level & (st_reg.s2 | st_reg.s3));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.level;

endmodule
`default_nettype wire

// [design/output_select.sv]
// picks the level that one output terminal shows from its selection code
`timescale 1ns/1ps
`default_nettype none
module output_select (
  // selection
  input wire logic [7:0] code_i,
  // sources
  input wire logic [dio_pkg::FUNC_W-1:0] func_i,
  input wire logic [dio_pkg::GP_W-1:0] gp_i,
  input wire logic [dio_pkg::STATUS_W-1:0] status_i,
  // picked level
  output logic level_o
);
  import dio_pkg::*;

  logic echo_code;

  // echo codes are the input codes minus the general bits and 24, 25, 27
  assign echo_code = in_code_valid(code_i) &&
                     code_i != CODE_FAULT_CLEAR &&
                     code_i != CODE_POSITION_PRESET &&
                     code_i != CODE_PANEL_LOCK;

  always_comb begin
    level_o = 1'b0;
    if (code_i >= CODE_GENERAL_BIT_ZERO &&
        code_i <= CODE_GENERAL_BIT_FIFTEEN) begin
      level_o = gp_i[code_i[3:0]];
    end else if (echo_code) begin
      level_o = func_i[code_i[5:0]];
    end else begin
      case (code_i)
        CODE_FAULT: level_o = !status_i[ST_FAULT];
        CODE_CAUTION: level_o = status_i[ST_CAUTION];
        CODE_READY: level_o = status_i[ST_READY];
        CODE_MOVING: level_o = status_i[ST_MOVING];
        CODE_HOME_POS: level_o = status_i[ST_HOME_POS];
        CODE_ROTATION_TICK: level_o = status_i[ST_TICK];
        CODE_ZONE_ONE: level_o = status_i[ST_ZONE_ONE];
        CODE_ZONE_TWO: level_o = status_i[ST_ZONE_TWO];
        CODE_ZONE_THREE: level_o = status_i[ST_ZONE_THREE];
        CODE_INTERNAL_BUSY: level_o = status_i[ST_BUSY];
        default: level_o = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// [sim/terminal_peer.sv]
// far-side controller model that works the input terminal contacts
`timescale 1ns/1ps
`default_nettype none
module terminal_peer (
  // clock
  input wire logic clk_i,
  // requested contact states and pace
  input wire logic [3:0] want_i,
  input wire logic slow_i,
  // terminal pins, 1 = conducting
  output logic [3:0] pins_o
);
  logic [3:0] lag;
  // slow contacts close two edges late, like a relay on a long cable
  always @(posedge clk_i) begin
    lag <= want_i;
    pins_o <= slow_i ? lag : want_i;
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
// self-checking bench of the direct terminal function mux
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dio_pkg::*;
  logic clk, rst, wr, rd, net_pl, slow;
  logic [7:0] addr, wdata, rdata, d;
  logic [3:0] want, pins;
  logic [1:0] outs;
  logic [63:0] net, func;
  logic [15:0] gp;
  logic [9:0] st;
  logic [5:0] opno;
  int num_errors = 0;
  int n_checks = 0;
  localparam logic [63:0] B27 = 64'h1 << 27;
  localparam logic [63:0] B60 = 64'h1 << 60;
  localparam logic [63:0] B18 = 64'h1 << 18;
  localparam logic [15:0] GP_PAT = 16'ha5c3;
  localparam logic [5:0] OPN = 6'h2b;
  logic [7:0] rst_tab [8] = '{8'h3c, 8'h3d, 8'h3e, 8'h12, 8'h00, 8'h41,
                              8'h43, 8'h10};
  logic [7:0] st_code [10] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h46, 8'h48,
                               8'h49, 8'h4a, 8'h4b, 8'h50};
  logic [7:0] bad_out [6] = '{8'h00, 8'h1b, 8'h40, 8'h45, 8'h51, 8'hff};

  direct_io_function_mux i_direct_io_function_mux (
    .CORE_CLK_I(clk), .RST_I(rst), .IN_TERM_I(pins), .OUT_TERM_O(outs),
    .NET_FUNC_I(net), .NET_PANEL_LOCK_ASSIGNED_I(net_pl),
    .GENERAL_BITS_I(gp), .FAULT_I(st[0]), .CAUTION_I(st[1]),
    .READY_I(st[2]), .MOVING_I(st[3]), .HOME_POS_I(st[4]),
    .ROTATION_TICK_I(st[5]), .ZONE_I(st[8:6]), .INTERNAL_BUSY_I(st[9]),
    .FUNC_O(func), .OP_DATA_NO_O(opno), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata)
  );

  terminal_peer i_terminal_peer (
    .clk_i(clk), .want_i(want), .slow_i(slow), .pins_o(pins)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the read edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic pins_to(input logic [3:0] v);
    @(posedge clk);
    want <= v;
    settle(10);
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    {wr, rd, net_pl, slow} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    want = 4'h0;
    net = '0;
    gp = '0;
    st = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    chk(outs, 2'b01);
    for (int i = 0; i < 8; i++) begin
      rd_reg(8'(i), d);
      chk(d, rst_tab[i]);
    end
    rd_reg(8'h20, d);
    chk(d, 8'h00);
    @(posedge clk);
    st <= 10'h005;
    settle(3);
    chk(outs, 2'b10);
    // each status code follows its own source only, fault inverted
    for (int i = 0; i < 10; i++) begin
      wr_reg(ADDR_OUT_SEL0, st_code[i]);
      @(posedge clk);
      st <= 10'h1 << i;
      settle(3);
      chk(outs[0], i != 0);
      @(posedge clk);
      st <= ~(10'h1 << i);
      settle(3);
      chk(outs[0], i == 0);
    end
    @(posedge clk);
    st <= '1;
    gp <= '1;
    for (int i = 0; i < 6; i++) begin
      wr_reg(ADDR_OUT_SEL0, bad_out[i]);
      settle(3);
      chk(outs[0], 1'b0);
    end
    @(posedge clk);
    st <= '0;
    gp <= GP_PAT;
    for (int i = 0; i < 16; i++) begin
      wr_reg(ADDR_OUT_SEL0, 8'h20 + 8'(i));
      settle(3);
      chk(outs[0], GP_PAT[i]);
    end
    @(posedge clk);
    net <= 64'(OPN) << 48;
    settle(3);
    chk(opno, OPN);
    for (int i = 0; i < 6; i++) begin
      wr_reg(ADDR_OUT_SEL1, 8'h30 + 8'(i));
      settle(3);
      chk(outs[1], OPN[i]);
    end
    @(posedge clk);
    net <= '0;
    slow <= 1'b1;
    pins_to(4'b0001);
    chk(func, B60 | B27);
    wr_reg(ADDR_OUT_SEL1, CODE_POSITIVE_LIMIT);
    settle(3);
    chk(outs[1], 1'b1);
    wr_reg(ADDR_IN_POL, 8'h01);
    settle(10);
    chk(func, B27);
    wr_reg(ADDR_IN_POL, 8'h0f);
    pins_to(4'b0000);
    chk(func, B60 | (B60 << 1) | (B60 << 2) | B18 | B27);
    wr_reg(ADDR_IN_POL, 8'h00);
    wr_reg(ADDR_IN_SEL1, CODE_POSITIVE_LIMIT);
    pins_to(4'b0010);
    chk(func, B60 | B27);
    wr_reg(ADDR_IN_SEL2, 8'h14);
    pins_to(4'b0100);
    chk(func, B27);
    wr_reg(ADDR_IN_SEL3, CODE_PANEL_LOCK);
    pins_to(4'b0000);
    chk(func, 64'h0);
    @(posedge clk);
    net_pl <= 1'b1;
    pins_to(4'b1000);
    chk(func, 64'h0);
    @(posedge clk);
    net <= B27;
    settle(3);
    chk(func, B27);
    // a second reset must bring back every selection and polarity
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    chk(outs, 2'b01);
    for (int i = 0; i < 7; i++) begin
      rd_reg(8'(i), d);
      chk(d, rst_tab[i]);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
